/* rtl/utg_pkg.sv */
package utg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 32;
    localparam int STRB_W  = 4;
    localparam int IDX_W   = 8;
    localparam int IDX_LSB = 2;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_HSTART  = 8'h5c;
    localparam logic [IDX_W-1:0] IDX_HSTOP   = 8'h5d;
    localparam logic [IDX_W-1:0] IDX_VSTART  = 8'h5e;
    localparam logic [IDX_W-1:0] IDX_VSTOP   = 8'h5f;
    localparam logic [IDX_W-1:0] IDX_COMBPOL = 8'h60;
    localparam logic [IDX_W-1:0] IDX_STATUS  = 8'h70;

    ////////////////////////////////////////////////////////////////////////
    // field layout
    localparam int PIX_W   = 16;
    localparam int LINE_W  = 15;
    localparam int REG_W   = 16;
    localparam int BIT_XOR = 0;
    localparam int BIT_OR  = 1;
    localparam int BIT_AND = 2;
    localparam int BIT_POL = 3;
    localparam int ST_HWIN = 0;
    localparam int ST_VWIN = 1;
    localparam int ST_OUT  = 2;

    localparam logic [REG_W-1:0] MASK_H  = 16'hffff;
    localparam logic [REG_W-1:0] MASK_V  = 16'h7fff;
    localparam logic [REG_W-1:0] MASK_OP = 16'h000f;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [REG_W-1:0] RST_WIN     = 16'h0000;
    localparam logic [REG_W-1:0] RST_COMBPOL = 16'h0008;
    localparam logic             RST_OUT     = 1'b1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [PIX_W-1:0]  hstart;
        logic [PIX_W-1:0]  hstop;
        logic [LINE_W-1:0] vstart;
        logic [LINE_W-1:0] vstop;
        logic [REG_W-1:0]  combpol;
    } utg_cfg_t;

    typedef struct packed {
        logic [PIX_W-1:0]  pix;
        logic [LINE_W-1:0] line;
    } utg_pos_t;

endpackage : utg_pkg

/* rtl/utg_top.sv */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module utg_top (
    input  wire logic                        core_clk,             // pixel clock, 250 MHz
    input  wire logic                        rstn,                 // async reset, active low
    input  wire utg_pkg::utg_pos_t           pos,                  // current pixel and field line
    input  wire logic [utg_pkg::ADDR_W-1:0]  s_axi_awaddr,         // write address
    input  wire logic [2:0]                  s_axi_awprot,         // unused protection
    input  wire logic                        s_axi_awvalid,        // write address valid
    output logic                             s_axi_awready,        // write address ready
    input  wire logic [utg_pkg::DATA_W-1:0]  s_axi_wdata,          // write data
    input  wire logic [utg_pkg::STRB_W-1:0]  s_axi_wstrb,          // write byte lanes
    input  wire logic                        s_axi_wvalid,         // write data valid
    output logic                             s_axi_wready,         // write data ready
    output logic [1:0]                       s_axi_bresp,          // write response
    output logic                             s_axi_bvalid,         // write response valid
    input  wire logic                        s_axi_bready,         // write response ready
    input  wire logic [utg_pkg::ADDR_W-1:0]  s_axi_araddr,         // read address
    input  wire logic [2:0]                  s_axi_arprot,         // unused protection
    input  wire logic                        s_axi_arvalid,        // read address valid
    output logic                             s_axi_arready,        // read address ready
    output logic [utg_pkg::DATA_W-1:0]       s_axi_rdata,          // read data
    output logic [1:0]                       s_axi_rresp,          // read response
    output logic                             s_axi_rvalid,         // read data valid
    input  wire logic                        s_axi_rready,         // read data ready
    output logic                             custom_horiz_window,  // horizontal window, high active
    output logic                             custom_vert_window,   // vertical window, high active
    output logic                             custom_timing_output  // final user signal two
);

    ////////////////////////////////////////////////////////////////////////
    // address decode and write merge helpers

    function automatic logic idx_hit(
        input logic [utg_pkg::ADDR_W-1:0] addr,
        input logic [utg_pkg::IDX_W-1:0]  idx
    );
        logic [utg_pkg::ADDR_W-1:0] want;
        want = {{(utg_pkg::ADDR_W-utg_pkg::IDX_W-utg_pkg::IDX_LSB){1'b0}},
                idx, {utg_pkg::IDX_LSB{1'b0}}};
        // low two address bits are ignored: every register is one aligned word
        idx_hit = (addr[utg_pkg::ADDR_W-1:utg_pkg::IDX_LSB]
                   == want[utg_pkg::ADDR_W-1:utg_pkg::IDX_LSB]);
    endfunction : idx_hit

    function automatic logic [utg_pkg::REG_W-1:0] merge(
        input logic [utg_pkg::REG_W-1:0]  old,
        input logic [utg_pkg::DATA_W-1:0] data,
        input logic [utg_pkg::STRB_W-1:0] strb,
        input logic [utg_pkg::REG_W-1:0]  mask
    );
        logic [utg_pkg::REG_W-1:0] val;
        val = old;
        if (strb[0]) begin
            val[7:0] = data[7:0];
        end
        if (strb[1]) begin
            val[15:8] = data[15:8];
        end
        // reserved bits are not stored, so a stray one cannot steer the output
        merge = val & mask;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    // configuration and status state

    utg_pkg::utg_cfg_t cfg_reg;
    utg_pkg::utg_cfg_t cfg_next;
    logic              hwin_reg;
    logic              hwin_next;
    logic              vwin_reg;
    logic              vwin_next;
    logic              out_reg;
    logic              out_next;

    ////////////////////////////////////////////////////////////////////////
    // write channel state

    logic                        aw_hold_reg;
    logic                        aw_hold_next;
    logic [utg_pkg::ADDR_W-1:0]  aw_addr_reg;
    logic [utg_pkg::ADDR_W-1:0]  aw_addr_next;
    logic                        w_hold_reg;
    logic                        w_hold_next;
    logic [utg_pkg::DATA_W-1:0]  w_data_reg;
    logic [utg_pkg::DATA_W-1:0]  w_data_next;
    logic [utg_pkg::STRB_W-1:0]  w_strb_reg;
    logic [utg_pkg::STRB_W-1:0]  w_strb_next;
    logic                        bvalid_reg;
    logic                        bvalid_next;
    logic [1:0]                  bresp_reg;
    logic [1:0]                  bresp_next;
    logic                        wr_do;

    ////////////////////////////////////////////////////////////////////////
    // read channel state

    logic                        rvalid_reg;
    logic                        rvalid_next;
    logic [utg_pkg::DATA_W-1:0]  rdata_reg;
    logic [utg_pkg::DATA_W-1:0]  rdata_next;
    logic [1:0]                  rresp_reg;
    logic [1:0]                  rresp_next;

    // a new address or data beat waits until the previous response is gone
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // write path: address and data are latched in any order, then applied

    assign wr_do = aw_hold_reg && w_hold_reg;

    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next  = w_hold_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        cfg_next     = cfg_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_do) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = utg_pkg::RESP_OKAY;
            if (idx_hit(aw_addr_reg, utg_pkg::IDX_HSTART)) begin
                cfg_next.hstart = merge(cfg_reg.hstart, w_data_reg, w_strb_reg,
                                        utg_pkg::MASK_H);
            end else if (idx_hit(aw_addr_reg, utg_pkg::IDX_HSTOP)) begin
                cfg_next.hstop = merge(cfg_reg.hstop, w_data_reg, w_strb_reg,
                                       utg_pkg::MASK_H);
            end else if (idx_hit(aw_addr_reg, utg_pkg::IDX_VSTART)) begin
                cfg_next.vstart = utg_pkg::LINE_W'(merge({1'b0, cfg_reg.vstart},
                                  w_data_reg, w_strb_reg, utg_pkg::MASK_V));
            end else if (idx_hit(aw_addr_reg, utg_pkg::IDX_VSTOP)) begin
                cfg_next.vstop = utg_pkg::LINE_W'(merge({1'b0, cfg_reg.vstop},
                                 w_data_reg, w_strb_reg, utg_pkg::MASK_V));
            end else if (idx_hit(aw_addr_reg, utg_pkg::IDX_COMBPOL)) begin
                cfg_next.combpol = merge(cfg_reg.combpol, w_data_reg, w_strb_reg,
                                         utg_pkg::MASK_OP);
            end else begin
                // status is read only, and holes answer with an error
                bresp_next = utg_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_hold_reg     <= 1'b0;
            aw_addr_reg     <= '0;
            w_hold_reg      <= 1'b0;
            w_data_reg      <= '0;
            w_strb_reg      <= '0;
            bvalid_reg      <= 1'b0;
            bresp_reg       <= utg_pkg::RESP_OKAY;
            cfg_reg.hstart  <= utg_pkg::RST_WIN;
            cfg_reg.hstop   <= utg_pkg::RST_WIN;
            cfg_reg.vstart  <= utg_pkg::LINE_W'(utg_pkg::RST_WIN);
            cfg_reg.vstop   <= utg_pkg::LINE_W'(utg_pkg::RST_WIN);
            cfg_reg.combpol <= utg_pkg::RST_COMBPOL;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg  <= w_hold_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            cfg_reg     <= cfg_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: data is answered the cycle after the address is taken

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next  = '0;
            rresp_next  = utg_pkg::RESP_OKAY;
            if (idx_hit(s_axi_araddr, utg_pkg::IDX_HSTART)) begin
                rdata_next[utg_pkg::PIX_W-1:0] = cfg_reg.hstart;
            end else if (idx_hit(s_axi_araddr, utg_pkg::IDX_HSTOP)) begin
                rdata_next[utg_pkg::PIX_W-1:0] = cfg_reg.hstop;
            end else if (idx_hit(s_axi_araddr, utg_pkg::IDX_VSTART)) begin
                rdata_next[utg_pkg::LINE_W-1:0] = cfg_reg.vstart;
            end else if (idx_hit(s_axi_araddr, utg_pkg::IDX_VSTOP)) begin
                rdata_next[utg_pkg::LINE_W-1:0] = cfg_reg.vstop;
            end else if (idx_hit(s_axi_araddr, utg_pkg::IDX_COMBPOL)) begin
                rdata_next[utg_pkg::REG_W-1:0] = cfg_reg.combpol;
            end else if (idx_hit(s_axi_araddr, utg_pkg::IDX_STATUS)) begin
                rdata_next[utg_pkg::ST_HWIN] = hwin_reg;
                rdata_next[utg_pkg::ST_VWIN] = vwin_reg;
                rdata_next[utg_pkg::ST_OUT]  = out_reg;
            end else begin
                rresp_next = utg_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= utg_pkg::RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // window generation and combination

    logic h_act;
    logic v_act;
    logic comb;

    always_comb begin
        // windows include the start position and end before the stop position;
        // a start not below the stop simply gives an empty window
        h_act = (pos.pix >= cfg_reg.hstart) && (pos.pix < cfg_reg.hstop);
        // the line count is field relative, so values apply alike in every field
        v_act = (pos.line >= cfg_reg.vstart) && (pos.line < cfg_reg.vstop);
        if (cfg_reg.combpol[utg_pkg::BIT_AND]) begin
            comb = h_act && v_act;
        end else if (cfg_reg.combpol[utg_pkg::BIT_OR]) begin
            comb = h_act || v_act;
        end else if (cfg_reg.combpol[utg_pkg::BIT_XOR]) begin
            comb = h_act ^ v_act;
        end else begin
            comb = 1'b0;
        end
        hwin_next = h_act;
        vwin_next = v_act;
        // polarity set means the final signal idles high and pulses low
        out_next = cfg_reg.combpol[utg_pkg::BIT_POL] ? !comb : comb;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hwin_reg <= 1'b0;
            vwin_reg <= 1'b0;
            out_reg  <= utg_pkg::RST_OUT;
        end else begin
            hwin_reg <= hwin_next;
            vwin_reg <= vwin_next;
            out_reg  <= out_next;
        end
    end

    assign custom_horiz_window  = hwin_reg;
    assign custom_vert_window   = vwin_reg;
    assign custom_timing_output = out_reg;

endmodule : utg_top

`default_nettype wire

/* sim/utg_chk.sv */
`timescale 1ns/1ns
`default_nettype none

module utg_chk (
    input wire logic                       core_clk,             // pixel clock
    input wire logic                       rstn,                 // async reset, active low
    input wire utg_pkg::utg_pos_t          pos,                  // pixel and line
    input wire logic [utg_pkg::ADDR_W-1:0] s_axi_awaddr,         // write address
    input wire logic                       s_axi_awvalid,        // write address valid
    input wire logic                       s_axi_awready,        // write address ready
    input wire logic [utg_pkg::DATA_W-1:0] s_axi_wdata,          // write data
    input wire logic                       s_axi_wvalid,         // write data valid
    input wire logic                       s_axi_wready,         // write data ready
    input wire logic                       s_axi_bvalid,         // write response valid
    input wire logic                       s_axi_arvalid,        // read address valid
    input wire logic                       s_axi_arready,        // read address ready
    input wire logic                       s_axi_rvalid,         // read data valid
    input wire logic                       custom_horiz_window,  // horizontal window
    input wire logic                       custom_vert_window,   // vertical window
    input wire logic                       custom_timing_output  // final output
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////
    // shadow of the config; assumes address and data are taken at one edge
    logic [7:0]  wr_idx;
    logic [15:0] wr_dat;
    logic        wr_go;
    logic [15:0] hs, he;
    logic [14:0] vs, ve;
    logic [3:0]  op;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_go <= 1'b0;
            wr_idx <= 8'h00;
            wr_dat <= 16'h0000;
            hs <= 16'h0000;
            he <= 16'h0000;
            vs <= 15'h0000;
            ve <= 15'h0000;
            op <= 4'h8;
        end else begin
            wr_go <= s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) wr_idx <= s_axi_awaddr[9:2];
            if (s_axi_wvalid && s_axi_wready) wr_dat <= s_axi_wdata[15:0];
            if (wr_go) begin
                case (wr_idx)
                    8'h5c: hs <= wr_dat;
                    8'h5d: he <= wr_dat;
                    8'h5e: vs <= wr_dat[14:0];
                    8'h5f: ve <= wr_dat[14:0];
                    8'h60: op <= wr_dat[3:0];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    wr_answer_a: assert property (wr_take |-> ##1 wr_answer)
        else $error("write response not on time");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response not on time");
    busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    pol_reset_a: assert property ($rose(rstn) |-> custom_timing_output)
        else $error("output not inactive high after reset");
    hwin_track_a: assert property (custom_horiz_window ==
        ($past(hs) <= $past(pos.pix) && $past(pos.pix) < $past(he)))
        else $error("horizontal window wrong");
    vwin_track_a: assert property (custom_vert_window ==
        ($past(vs) <= $past(pos.line) && $past(pos.line) < $past(ve)))
        else $error("vertical window wrong");
    and_sel_a: assert property ($past(op[2]) |-> custom_timing_output ==
        ((custom_horiz_window & custom_vert_window) ^ $past(op[3])))
        else $error("and combine wrong");
    or_sel_a: assert property ($past(op[2:1]) == 2'h1 |-> custom_timing_output ==
        ((custom_horiz_window | custom_vert_window) ^ $past(op[3])))
        else $error("or combine wrong");
    xor_sel_a: assert property ($past(op[2:0]) == 3'h1 |-> custom_timing_output ==
        ((custom_horiz_window ^ custom_vert_window) ^ $past(op[3])))
        else $error("xor combine wrong");
    no_op_a: assert property ($past(op[2:0]) == 3'h0 |-> custom_timing_output == $past(op[3]))
        else $error("idle combine wrong");
endmodule : utg_chk

`default_nettype wire

/* sim/user_timing_signal_two_gen_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module user_timing_signal_two_gen_bench;
    logic              core_clk = 1'b0;
    logic              rstn = 1'b0;
    utg_pkg::utg_pos_t pos = '0;
    logic [11:0]       s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              custom_horiz_window, custom_vert_window, custom_timing_output;
    int                err_count = 0, checked = 0, cycles = 0, op, i, j;
    logic              hx, vx;
    logic [15:0]       px [4] = '{16'h0009, 16'h000a, 16'h0013, 16'h0014};
    logic [14:0]       ln [4] = '{15'h0004, 15'h0005, 15'h0007, 15'h0008};

    always #2 core_clk = ~core_clk;

    utg_top i_dut (.core_clk, .rstn, .pos, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .custom_horiz_window, .custom_vert_window, .custom_timing_output);

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    // the whole run needs well under 2000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            close_out();
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic got;
        got = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!got) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) got = 1'b1;
        end
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic got;
        got = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) got = 1'b1;
        end
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, exp);
        check({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(12'h170, 32'h0, utg_pkg::RESP_OKAY);
        rd(12'h174, 32'h0, utg_pkg::RESP_OKAY);
        rd(12'h178, 32'h0, utg_pkg::RESP_OKAY);
        rd(12'h17c, 32'h0, utg_pkg::RESP_OKAY);
        rd(12'h180, 32'h8, utg_pkg::RESP_OKAY);
        check({31'h0, custom_timing_output}, 32'h1);
        $display("test defaults done");
        // reserved bits written as zero, stop before start; holes and status refuse writes
        wr(12'h17c, 32'h0000_0008, utg_pkg::RESP_OKAY);
        rd(12'h17c, 32'h0008, utg_pkg::RESP_OKAY);
        wr(12'h178, 32'h0000_0005, utg_pkg::RESP_OKAY);
        rd(12'h178, 32'h0005, utg_pkg::RESP_OKAY);
        wr(12'h180, 32'h0000_0000, utg_pkg::RESP_OKAY);
        rd(12'h180, 32'h0, utg_pkg::RESP_OKAY);
        wr(12'h200, 32'h1, utg_pkg::RESP_SLVERR);
        wr(12'h1c0, 32'h7, utg_pkg::RESP_SLVERR);
        rd(12'h200, 32'h0, utg_pkg::RESP_SLVERR);
        $display("test register access done");
        // stop goes in first so start never sits at or above it
        wr(12'h174, 32'h0014, utg_pkg::RESP_OKAY);
        wr(12'h170, 32'h000a, utg_pkg::RESP_OKAY);
        wr(12'h17c, 32'h0008, utg_pkg::RESP_OKAY);
        wr(12'h178, 32'h0005, utg_pkg::RESP_OKAY);
        // every operator code, each pixel and line one step either side of the edges
        for (op = 0; op < 16; op++) begin
            wr(12'h180, {28'h0, op[3:0]}, utg_pkg::RESP_OKAY);
            for (i = 0; i < 4; i++) begin
                for (j = 0; j < 4; j++) begin
                    pos <= {px[i], ln[j]};
                    hx = (px[i] >= 16'h000a) && (px[i] < 16'h0014);
                    vx = (ln[j] >= 15'h0005) && (ln[j] < 15'h0008);
                    @(posedge core_clk);
                    @(posedge core_clk);
                    check({31'h0, custom_horiz_window}, {31'h0, hx});
                    check({31'h0, custom_vert_window}, {31'h0, vx});
                    check({31'h0, custom_timing_output}, {31'h0, (op[2] ? hx & vx : op[1] ?
                        hx | vx : op[0] ? hx ^ vx : 1'b0) ^ op[3]});
                end
            end
        end
        pos <= {16'h000a, 15'h0005};
        @(posedge core_clk);
        @(posedge core_clk);
        rd(12'h1c0, 32'h3, utg_pkg::RESP_OKAY);
        $display("test combine done");
        // a second reset must bring back the defaults
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd(12'h180, 32'h8, utg_pkg::RESP_OKAY);
        rd(12'h170, 32'h0, utg_pkg::RESP_OKAY);
        $display("test second reset done");
        close_out();
    end
endmodule : user_timing_signal_two_gen_bench

bind utg_top utg_chk i_chk (.core_clk, .rstn, .pos, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .custom_horiz_window, .custom_vert_window, .custom_timing_output);

`default_nettype wire
